//--- verilog/diwd_map.svh
`ifndef DIWD_MAP_SVH
`define DIWD_MAP_SVH
// Digit codes
`define DIWD_DIG_MINUS 4'hA
`define DIWD_DIG_PERIOD 4'hB
// Register byte offsets
`define DIWD_OFF_CTRL 8'h00
`define DIWD_OFF_INSTR_LO 8'h04
`define DIWD_OFF_INSTR_HI 8'h08
`define DIWD_OFF_INDEX_LO 8'h0C
`define DIWD_OFF_INDEX_HI 8'h10
`define DIWD_OFF_COUNTER 8'h14
`define DIWD_OFF_STATUS 8'h18
`define DIWD_OFF_EFFADDR 8'h1C
`define DIWD_OFF_INDEXOUT_LO 8'h20
`define DIWD_OFF_INDEXOUT_HI 8'h24
`define DIWD_OFF_FIELDS 8'h28
`define DIWD_OFF_OPERAND_LO 8'h2C
`define DIWD_OFF_OPERAND_HI 8'h30
`define DIWD_OFF_CLASS 8'h34
// Address map limits (BCD)
`define DIWD_MAIN_LAST 20'h9_7499
`define DIWD_FAST_FIRST 20'h9_9901
`define DIWD_FAST_LAST 20'h9_9999
// Control bits
`define DIWD_CTRL_DECODE 0
`define DIWD_CTRL_LOOP 1
`define DIWD_CTRL_SUBTRACT 2
`define DIWD_CTRL_TRANSFER 3
`define DIWD_CTRL_ROUNDVAR 4
// Reset values
`define DIWD_RST_COUNTER 20'h0_0000
`endif

//--- verilog/diwd_pkg.sv
package diwd_pkg;
    typedef logic [3:0] diwd_digit_t;
    typedef struct packed {
        diwd_digit_t trace;
        logic [7:0] opcode;
        logic [7:0] arithReg;
        logic [7:0] indexReg;
        logic [19:0] address;
    } diwd_instr_t;
    typedef struct packed {
        logic [11:0] cycleCount;
        logic [15:0] step;
        logic [19:0] modifier;
    } diwd_index_t;
    typedef enum logic [1:0] {
        DIWD_DEST_MAIN = 2'b00,
        DIWD_DEST_FAST = 2'b01,
        DIWD_DEST_NONE = 2'b10
    } diwd_dest_t;
endpackage : diwd_pkg

//--- verilog/diwd_decoder.sv
// What this block does
// (RULE1) Fixed-point sign digit: zero positive, minus digit negative; point after sign.
// (RULE2) Absolute zero: period sign digit with all numeric digits zero.
// (RULE3) Single float: sign, two-digit excess-fifty exponent, nine mantissa digits.
// (RULE4) Floating operands kept normalized; leading mantissa digit never zero.
// (RULE5) Double fixed: two words, eleven digits each, both signs equal.
// (RULE6) Double float: first word sign, exponent, nine digits; second sign, eleven.
// (RULE7) Instruction splits into trace, opcode, arithmetic, index and address fields.
// (RULE8) Trace digit one to nine selects tracing routine; period means untraced.
// (RULE9) Any other trace character diverts to the error routine.
// (RULE10) Opcode outside the repertoire diverts to the error routine.
// (RULE11) Selected index modifier is added to the address before execution.
// (RULE12) Index selector double zero leaves the address unmodified.
// (RULE13) Index word: three-digit count, four-digit step, five-digit modifier.
// (RULE14) Loop count decrements per traversal; iteration ends at zero.
// (RULE15) Step added to or subtracted from modifier before each traversal.
// (RULE16) Addresses 00000 to 97499 go to main storage.
// (RULE17) Addresses 99901 to 99999 go to the fast registers.
// (RULE18) Flip-flop addressing takes the address from the arithmetic field.
// (RULE19) Control counter advances by one unless control is transferred.
// (RULE20) Only rounding variants round; other results stay unrounded. Here they round only with DIWD_CTRL_ROUNDVAR set.
// (RULE21) Double operand in fast registers uses named register and the next.
// (RULE22) Decode covers fetch, modification and checks; I/O runs in parallel.
// (RULE23) Each digit has a fixed binary code: 0-9, minus and period.
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`include "diwd_map.svh"
`timescale 1ns/1ps
`default_nettype none
module diwd_decoder
    import diwd_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic errorDivert,
    output logic traceActive,
    output logic fastSelect
);
    diwd_instr_t instr;
    diwd_index_t indexIn;
    diwd_index_t indexOut;
    logic [19:0] counter;
    logic [19:0] effAddr;
    logic [4:0] ctrl;
    logic [7:0] flipflop_select;
    logic [7:0] fastRegNext;
    diwd_dest_t dest;
    logic loopDone;
    logic roundEnable;
    logic [47:0] operand;
    logic [5:0] classFlags;
    logic [19:0] next_effAddr;
    logic [19:0] next_modifier;
    logic [19:0] next_counter;
    logic [11:0] next_cycle;
    logic [47:0] instrWord;
    logic [47:0] indexWord;
    logic wrEn;
    logic rdEn;
    logic decodeGo;
    logic loopGo;
    logic traceOk;
    logic traceOn;
    logic opOk;
    logic digitsOk;

    // BCD add of five digits, wraps at 99999
    function automatic logic [19:0] bcdAdd(input logic [19:0] a, input logic [19:0] b);
        logic [19:0] r;
        logic [4:0] s;
        logic c;
        r = 20'h0_0000;
        c = 1'b0;
        for (int i = 0; i < 5; i++) begin
            s = {1'b0, a[i*4 +: 4]} + {1'b0, b[i*4 +: 4]} + {4'h0, c};
            c = (s > 5'd9);
            r[i*4 +: 4] = c ? 4'(s - 5'd10) : s[3:0];
        end
        return r;
    endfunction : bcdAdd

    // Nines complement plus one gives a BCD subtract
    function automatic logic [19:0] bcdSub(input logic [19:0] a, input logic [19:0] b);
        logic [19:0] nc;
        nc = 20'h0_0000;
        for (int i = 0; i < 5; i++) begin
            nc[i*4 +: 4] = 4'h9 - b[i*4 +: 4];
        end
        return bcdAdd(bcdAdd(a, nc), 20'h0_0001);
    endfunction : bcdSub

    function automatic logic isNum(input diwd_digit_t d);
        return d <= 4'h9; // see (RULE23)
    endfunction : isNum

    // Repertoire of defined operation codes
    function automatic logic opValid(input logic [7:0] op);
        unique case (op)
            8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h11, 8'h12, 8'h14, 8'h15, 8'h16,
            8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27,
            8'h30, 8'h31, 8'h32, 8'h34, 8'h35, 8'h36, 8'h37,
            8'h40, 8'h41, 8'h42, 8'h43, 8'h45, 8'h46, 8'h47, 8'h48,
            8'h50, 8'h51, 8'h52, 8'h53, 8'h55, 8'h56, 8'h57, 8'h58, 8'h59,
            8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h66,
            8'h70, 8'h71, 8'h72, 8'h73, 8'h74, 8'h75, 8'h76,
            8'h80, 8'h81, 8'h90, 8'h91, 8'h92, 8'h95: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : opValid

    // Rounding variants of multiply and divide
    function automatic logic opRounds(input logic [7:0] op);
        return (op == 8'h20) || (op == 8'h22) || (op == 8'h32) || (op == 8'h34);
    endfunction : opRounds

    assign instrWord = instr;
    assign indexWord = indexIn;
    assign wrEn = psel && penable && pwrite;
    assign rdEn = psel && penable && !pwrite;

    // Software writes of words and control
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            instr <= '0;
            indexIn <= '0;
            ctrl <= 5'h00;
        end else if (wrEn) begin
            unique case (paddr)
                `DIWD_OFF_CTRL: ctrl <= pwdata[4:0];
                `DIWD_OFF_INSTR_LO: instr <= {instrWord[47:32], pwdata};
                `DIWD_OFF_INSTR_HI: instr <= {pwdata[15:0], instrWord[31:0]};
                `DIWD_OFF_INDEX_LO: indexIn <= {indexWord[47:32], pwdata};
                `DIWD_OFF_INDEX_HI: indexIn <= {pwdata[15:0], indexWord[31:0]};
                default: ;
            endcase
        end else begin
            ctrl[`DIWD_CTRL_DECODE] <= 1'b0;
            ctrl[`DIWD_CTRL_LOOP] <= 1'b0;
        end
    end

    assign decodeGo = ctrl[`DIWD_CTRL_DECODE];
    assign loopGo = ctrl[`DIWD_CTRL_LOOP];

    // Field checks on the split word
    assign traceOn = (instr.trace >= 4'h1) && (instr.trace <= 4'h9); // see (RULE7) see (RULE8)
    assign traceOk = traceOn || (instr.trace == `DIWD_DIG_PERIOD); // see (RULE9)
    assign opOk = opValid(instr.opcode); // see (RULE10)
    assign digitsOk = isNum(instr.opcode[7:4]) && isNum(instr.opcode[3:0]);

    // Address modification and routing
    always_comb begin
        next_effAddr = (instr.indexReg == 8'h00) ? instr.address // see (RULE12)
                     : bcdAdd(instr.address, indexIn.modifier); // see (RULE11)
        next_modifier = ctrl[`DIWD_CTRL_SUBTRACT] ? bcdSub(indexIn.modifier, {4'h0, indexIn.step}) // see (RULE15)
                      : bcdAdd(indexIn.modifier, {4'h0, indexIn.step});
        next_cycle = 12'(bcdSub({8'h00, indexIn.cycleCount}, 20'h0_0001)); // see (RULE14)
        next_counter = (ctrl[`DIWD_CTRL_TRANSFER] && traceOk && opOk) ? next_effAddr
                     : bcdAdd(counter, 20'h0_0001); // see (RULE19)
    end

    // Decode result registers; one step covers fetch, modify and checks
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            effAddr <= 20'h0_0000;
            counter <= `DIWD_RST_COUNTER;
            dest <= DIWD_DEST_MAIN;
            errorDivert <= 1'b0;
            traceActive <= 1'b0;
            fastSelect <= 1'b0;
            flipflop_select <= 8'h00;
            fastRegNext <= 8'h00;
            roundEnable <= 1'b0;
        end else if (decodeGo) begin // see (RULE22)
            effAddr <= next_effAddr;
            errorDivert <= !traceOk || !opOk || !digitsOk; // see (RULE9) see (RULE10)
            traceActive <= traceOn; // see (RULE8)
            flipflop_select <= instr.arithReg; // see (RULE18)
            fastRegNext <= 8'(instr.arithReg + 8'h01); // see (RULE21)
            roundEnable <= opRounds(instr.opcode) && ctrl[`DIWD_CTRL_ROUNDVAR]; // see (RULE20)
            counter <= next_counter; // see (RULE19)
            if (next_effAddr <= `DIWD_MAIN_LAST) begin // see (RULE16)
                dest <= DIWD_DEST_MAIN;
                fastSelect <= 1'b0;
            end else if (next_effAddr >= `DIWD_FAST_FIRST) begin // see (RULE17)
                dest <= DIWD_DEST_FAST;
                fastSelect <= 1'b1;
            end else begin
                dest <= DIWD_DEST_NONE;
                fastSelect <= 1'b0;
            end
        end
    end

    // Index word loop traversal
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            indexOut <= '0;
            loopDone <= 1'b0;
        end else if (loopGo) begin // see (RULE13)
            indexOut.step <= indexIn.step;
            indexOut.modifier <= next_modifier; // see (RULE15)
            indexOut.cycleCount <= next_cycle; // see (RULE14)
            loopDone <= (next_cycle == 12'h000); // see (RULE14)
        end
    end

    // Operand classification of the loaded word
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            operand <= '0;
            classFlags <= 6'h00;
        end else begin
            operand <= instrWord;
            classFlags[0] <= (operand[47:44] == 4'h0); // see (RULE1)
            classFlags[1] <= (operand[47:44] == `DIWD_DIG_MINUS); // see (RULE1)
            classFlags[2] <= (operand[47:44] == `DIWD_DIG_PERIOD) && (operand[43:0] == 44'h0); // see (RULE2)
            classFlags[3] <= (operand[35:32] != 4'h0); // see (RULE3) see (RULE4)
            classFlags[4] <= (operand[47:44] == indexWord[47:44]); // see (RULE5) see (RULE6)
            classFlags[5] <= isNum(operand[43:40]) && isNum(operand[39:36]);
        end
    end

    // APB read path; unmapped reads return zero with error
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && !penable) begin
                unique case (paddr)
                    `DIWD_OFF_CTRL: prdata <= {27'h0, ctrl};
                    `DIWD_OFF_INSTR_LO: prdata <= instrWord[31:0];
                    `DIWD_OFF_INSTR_HI: prdata <= {16'h0, instrWord[47:32]};
                    `DIWD_OFF_INDEX_LO: prdata <= indexWord[31:0];
                    `DIWD_OFF_INDEX_HI: prdata <= {16'h0, indexWord[47:32]};
                    `DIWD_OFF_COUNTER: prdata <= {12'h0, counter};
                    `DIWD_OFF_STATUS: prdata <= {16'h0, fastRegNext, 1'b0, roundEnable, dest,
                                                 loopDone, fastSelect, traceActive, errorDivert};
                    `DIWD_OFF_EFFADDR: prdata <= {12'h0, effAddr};
                    `DIWD_OFF_INDEXOUT_LO: prdata <= indexOut[31:0];
                    `DIWD_OFF_INDEXOUT_HI: prdata <= {16'h0, indexOut[47:32]};
                    `DIWD_OFF_FIELDS: prdata <= {8'h0, flipflop_select, instr.indexReg, instr.arithReg};
                    `DIWD_OFF_OPERAND_LO: prdata <= operand[31:0];
                    `DIWD_OFF_OPERAND_HI: prdata <= {16'h0, operand[47:32]};
                    `DIWD_OFF_CLASS: prdata <= {26'h0, classFlags};
                    default: pslverr <= !pwrite;
                endcase
            end
        end
    end

    logic unusedRd;
    assign unusedRd = rdEn;
endmodule : diwd_decoder
`default_nettype wire

//--- tb/diwd_decoder_checker.sv
`timescale 1ns/1ps
`default_nettype none
module diwd_decoder_checker (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic errorDivert,
    input wire logic traceActive,
    input wire logic fastSelect
);
    // Results land one cycle after the decode write, so a change is legal one or two samples later
    wire logic decWr = psel && penable && pwrite && (paddr == 8'h00) && pwdata[0];
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    property p_ready_next; psel && !penable |=> pready; endproperty
    a_ready_next: assert property (p_ready_next) else $error("pready missing after setup");
    property p_ready_access; pready |-> psel && penable; endproperty
    a_ready_access: assert property (p_ready_access) else $error("pready outside access");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than a cycle");
    property p_err_read; pslverr |-> pready && !pwrite; endproperty
    a_err_read: assert property (p_err_read) else $error("pslverr without read answer");
    property p_trace_cause; $changed(traceActive) |-> $past(decWr, 1) || $past(decWr, 2); endproperty
    a_trace_cause: assert property (p_trace_cause) else $error("trace flag moved without decode");
    property p_err_cause; $changed(errorDivert) |-> $past(decWr, 1) || $past(decWr, 2); endproperty
    a_err_cause: assert property (p_err_cause) else $error("error flag moved without decode");
    property p_fast_cause; $changed(fastSelect) |-> $past(decWr, 1) || $past(decWr, 2); endproperty
    a_fast_cause: assert property (p_fast_cause) else $error("fast flag moved without decode");
    property p_hold; !decWr [*3] |=> $stable(errorDivert) && $stable(traceActive); endproperty
    a_hold: assert property (p_hold) else $error("decode flags drifted");
endmodule : diwd_decoder_checker
bind diwd_decoder diwd_decoder_checker u_chk (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .errorDivert(errorDivert), .traceActive(traceActive), .fastSelect(fastSelect));
`default_nettype wire

//--- tb/diwd_store_model.sv
`timescale 1ns/1ps
`default_nettype none
module diwd_store_model (
    input wire logic [3:0] loc,
    output logic [47:0] word
);
    // Storage words as twelve digit codes, period B, minus A
    always_comb begin
        case (loc)
            4'h0: word = 48'hB430_1000_1234;
            4'h1: word = 48'h5020_1009_9950;
            4'h2: word = 48'h0430_1000_1234;
            4'h3: word = 48'hBAA0_1000_1234;
            4'h4: word = 48'hB430_1010_1234;
            4'h5: word = 48'hB430_1009_7499;
            4'h6: word = 48'hB430_1009_9901;
            4'h7: word = 48'hB430_1009_7500;
            4'h8: word = 48'h9950_7000_0010;
            4'hF: word = 48'h0010_0050_0100;
            // Empty locations read as a changing-looking pattern, not zero
            default: word = 48'hA5A5_5A5A_A5A5;
        endcase
    end
endmodule : diwd_store_model
`default_nettype wire

//--- tb/diwd_decoder_bench.sv
`timescale 1ns/1ps
`default_nettype none
module diwd_decoder_bench;
    import diwd_pkg::*;
    typedef struct packed {
        logic [3:0] loc;
        logic [2:0] flg;
        logic [19:0] eff;
    } diwd_row_t;
    localparam diwd_row_t ROWS [9] = '{'{4'h0, 3'b000, 20'h0_1234}, '{4'h1, 3'b110, 20'h9_9950},
        '{4'h2, 3'b001, 20'h0_1234}, '{4'h3, 3'b001, 20'h0_1234}, '{4'h4, 3'b000, 20'h0_1334},
        '{4'h5, 3'b000, 20'h9_7499}, '{4'h6, 3'b100, 20'h9_9901}, '{4'h7, 3'b000, 20'h9_7500},
        '{4'h8, 3'b010, 20'h0_0010}};
    logic mclk, nrst, psel, penable, pwrite, pready, pslverr, errorDivert, traceActive, fastSelect, slv;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0] loc;
    logic [47:0] word;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    diwd_decoder u_dut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .errorDivert(errorDivert), .traceActive(traceActive), .fastSelect(fastSelect));
    diwd_store_model u_store (.loc(loc), .word(word));
    task wrap_up;
        if (mismatches == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // Pready is read at the rising edge, before the slave's own update lands
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge mclk);
        end
        if (n == 50) mismatches++;
        rdat = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    task dec(input logic [31:0] c);
        apb(1'b1, 8'h00, c);
        repeat (2) @(posedge mclk);
    endtask : dec
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            wrap_up();
        end
    end
    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        loc = 4'hF;
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        chk("pins", 32'h0000_0000, {29'h0, fastSelect, traceActive, errorDivert});
        apb(1'b1, 8'h0C, word[31:0]);
        apb(1'b1, 8'h10, {16'h0000, word[47:32]});
        for (int i = 0; i < 9; i++) begin
            loc = ROWS[i].loc;
            @(posedge mclk);
            apb(1'b1, 8'h04, word[31:0]);
            apb(1'b1, 8'h08, {16'h0000, word[47:32]});
            dec(32'h0000_0001);
            apb(1'b0, 8'h18, 32'h0000_0000);
            chk("status", {29'h0, ROWS[i].flg}, {29'h0, rdat[2:0]});
            chk("pins", {29'h0, ROWS[i].flg}, {29'h0, fastSelect, traceActive, errorDivert});
            apb(1'b0, 8'h28, 32'h0000_0000);
            chk("fields", {8'h00, word[35:28], word[27:20], word[35:28]}, rdat);
            if (!ROWS[i].flg[0]) begin
                apb(1'b0, 8'h1C, 32'h0000_0000);
                chk("effaddr", {12'h000, ROWS[i].eff}, rdat);
            end
        end
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk("slverr", 32'h0000_0001, {31'h0, slv});
        chk("unmapped", 32'h0000_0000, rdat);
        // Counter is read-only: the write is dropped, nine row decodes plus this one give 10
        apb(1'b1, 8'h14, 32'h0000_0099);
        dec(32'h0000_0001);
        apb(1'b0, 8'h14, 32'h0000_0000);
        chk("counter", 32'h0000_0010, rdat);
        dec(32'h0000_0009);
        apb(1'b0, 8'h14, 32'h0000_0000);
        chk("jump", 32'h0000_0010, rdat);
        dec(32'h0000_0003);
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk("step add", 32'h0050_0105, rdat);
        apb(1'b0, 8'h24, 32'h0000_0000);
        chk("count", 32'h0000_0000, rdat);
        apb(1'b0, 8'h18, 32'h0000_0000);
        chk("done", 32'h0000_0001, {31'h0, rdat[3]});
        apb(1'b1, 8'h0C, 32'h0050_0100);
        apb(1'b1, 8'h10, 32'h0000_0010);
        dec(32'h0000_0007);
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk("step sub", 32'h0050_0095, rdat);
        apb(1'b1, 8'h08, 32'h0000_B220);
        dec(32'h0000_0011);
        apb(1'b0, 8'h18, 32'h0000_0000);
        chk("round on", 32'h0000_0001, {31'h0, rdat[6]});
        dec(32'h0000_0001);
        apb(1'b0, 8'h18, 32'h0000_0000);
        chk("round off", 32'h0000_0000, {31'h0, rdat[6]});
        wrap_up();
    end
endmodule : diwd_decoder_bench
`default_nettype wire
